// *** inc/i2c_link_pkg.sv ***
package i2c_link_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h36;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [3:0] LAST_BIT = 4'd8;
  localparam logic [3:0] ACK_BIT = 4'd9;

  // Valid, writable and pointer-hold register maps, one bit per address
  localparam logic [255:0] VALID_MAP_DEF = {1'b1, 255'h1c00f9ff};
  localparam logic [255:0] WRITE_MAP_DEF = {1'b1, 255'h000001fe};
  localparam logic [255:0] HOLD_MAP_DEF = 256'h08005000;

  localparam int REF_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 80;
  localparam int GLITCH_NS = 50;
  localparam int T_SCL_MIN_NS = 1000;
  localparam int T_BUF_NS = 500;

  localparam int FILT_REF_CYC =
    (GLITCH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int FILT_LINK_CYC =
    (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // A bit is four quarters: low, low, high, high
  localparam int QTR_NS = T_SCL_MIN_NS / 4;
  localparam logic [4:0] QTR_CYC =
    5'((QTR_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
  localparam logic [1:0] BUF_QTR = 2'((T_BUF_NS + QTR_NS - 1) / QTR_NS);

endpackage

// *** inc/i2c_link_if.sv ***
`timescale 1ns/100ps
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wired-and with pull-ups
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

  modport master (
    output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
    input scl, sda
  );
  modport slave (
    output s_sda_o, s_sda_oe,
    input scl, sda
  );
endinterface

// *** hw/i2c_line_filter.sv ***
`timescale 1ns/100ps
module i2c_line_filter #(
  parameter logic [3:0] STABLE = 4'd1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  import i2c_link_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic q;
    logic [3:0] cnt;
  } flt_t;

  flt_t r_r;
  flt_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = din;
    r_nxt.s2 = r_r.s1;
    // Output moves only after the new level held past the spike width
    if (r_r.s2 == r_r.q) begin
      r_nxt.cnt = 4'h0;
    end else if (r_r.cnt == STABLE) begin
      r_nxt.q = r_r.s2;
      r_nxt.cnt = 4'h0;
    end else begin
      r_nxt.cnt = r_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= '{s1: LINE_IDLE, s2: LINE_IDLE, q: LINE_IDLE, cnt: 4'h0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign dout = r_r.q;
endmodule

// *** hw/i2c_reg_slave.sv ***
// How it works
// - Answer only bus address 0x36 with ACK
// - Eighth address bit picks write or read
// - First write byte loads the register pointer
// - ACK valid pointer byte, NACK invalid one
// - Drop and NACK writes to invalid registers
// - Pointer steps after every data byte except reads of hold addresses, wraps around
// - Invalid register reads send zero byte
// - Sequential reads run on, pointer wrapping
// - Measurement high bytes hold pointer on read
// - Reads start from the current pointer value
// - Master ACKs all read bytes but last
// - After master NACK release SDA high
// - Bytes MSB first, ninth bit acknowledges
// - SDA edges while SCL high mark START/STOP
// - SDA changes only while SCL is low
// - ACK holds SDA low through clock high
// - Repeated START begins a new address byte
// - Master starts only on an idle bus
// - Master waits bus free time after STOP
// - Master keeps SCL phase minimums, 1 MHz
// - Filter spikes under 50 ns on lines
// - Never stretch SCL
`timescale 1ns/100ps
module i2c_reg_slave #(
  parameter logic [255:0] VALID_MAP = i2c_link_pkg::VALID_MAP_DEF,
  parameter logic [255:0] WRITE_MAP = i2c_link_pkg::WRITE_MAP_DEF,
  parameter logic [255:0] HOLD_MAP = i2c_link_pkg::HOLD_MAP_DEF
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  i2c_link_if.slave bus,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  import i2c_link_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_WORD, S_WDATA, S_RDATA, S_MACK
  } sl_st_t;

  typedef struct packed {
    sl_st_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic drv;
    logic mack;
    logic scl_p;
    logic sda_p;
    logic rq_tgl;
    logic rq_we;
    logic [7:0] rq_addr;
    logic [7:0] rq_wdata;
    logic ak1;
    logic ak2;
    logic ak3;
    logic [7:0] rdat;
    logic rst1;
    logic rst2;
  } lk_t;

  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic pend;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd_hold;
    logic ak_tgl;
  } rf_t;

  lk_t lk_r;
  lk_t lk_nxt;
  rf_t rf_r;
  rf_t rf_nxt;
  logic scl_f;
  logic sda_f;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] tx_byte;

  function automatic logic [7:0] rd_step(input logic [7:0] p);
    rd_step = HOLD_MAP[p] ? p : p + 8'h01;
  endfunction

  i2c_line_filter #(.STABLE(4'(FILT_LINK_CYC))) u_scl_flt (
    .clk(link_clk),
    .rst(lk_r.rst2),
    .din(bus.scl),
    .dout(scl_f)
  );

  i2c_line_filter #(.STABLE(4'(FILT_LINK_CYC))) u_sda_flt (
    .clk(link_clk),
    .rst(lk_r.rst2),
    .din(bus.sda),
    .dout(sda_f)
  );

  assign rise = scl_f && !lk_r.scl_p;
  assign fall = !scl_f && lk_r.scl_p;
  assign start_seen = scl_f && lk_r.scl_p && lk_r.sda_p && !sda_f;
  assign stop_seen = scl_f && lk_r.scl_p && !lk_r.sda_p && sda_f;
  assign tx_byte = VALID_MAP[lk_r.rq_addr] ? lk_r.rdat : 8'h00;

  // Link side, on the link clock
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.rst1 = sys_rst;
    lk_nxt.rst2 = lk_r.rst1;
    lk_nxt.ak1 = rf_r.ak_tgl;
    lk_nxt.ak2 = lk_r.ak1;
    lk_nxt.ak3 = lk_r.ak2;
    lk_nxt.scl_p = scl_f;
    lk_nxt.sda_p = sda_f;
    if (lk_r.ak2 != lk_r.ak3) begin
      lk_nxt.rdat = rf_r.rd_hold;
    end
    if (start_seen) begin
      lk_nxt.st = S_ADDR;
      lk_nxt.bcnt = 4'h0;
      lk_nxt.drv = 1'b0;
    end else if (stop_seen) begin
      lk_nxt.st = S_IDLE;
      lk_nxt.drv = 1'b0;
    end else begin
      unique case (lk_r.st)
        S_IDLE: begin
        end
        S_ADDR, S_WORD, S_WDATA: begin
          if (rise && lk_r.bcnt < LAST_BIT) begin
            lk_nxt.sh = {lk_r.sh[6:0], sda_f};
            lk_nxt.bcnt = lk_r.bcnt + 4'h1;
          end else if (fall && lk_r.bcnt == LAST_BIT) begin
            lk_nxt.bcnt = ACK_BIT;
            if (lk_r.st == S_ADDR) begin
              if (lk_r.sh[7:1] == DEV_ADDR) begin
                lk_nxt.drv = 1'b1;
                lk_nxt.rw = lk_r.sh[0];
                if (lk_r.sh[0] != DIR_WRITE) begin
                  lk_nxt.rq_addr = lk_r.ptr;
                  lk_nxt.rq_we = 1'b0;
                  lk_nxt.rq_tgl = !lk_r.rq_tgl;
                end
              end else begin
                lk_nxt.st = S_IDLE;
              end
            end else if (lk_r.st == S_WORD) begin
              lk_nxt.ptr = lk_r.sh;
              lk_nxt.drv = VALID_MAP[lk_r.sh];
            end else begin
              lk_nxt.ptr = lk_r.ptr + 8'h01;
              if (VALID_MAP[lk_r.ptr] && WRITE_MAP[lk_r.ptr]) begin
                lk_nxt.drv = 1'b1;
                lk_nxt.rq_addr = lk_r.ptr;
                lk_nxt.rq_wdata = lk_r.sh;
                lk_nxt.rq_we = 1'b1;
                lk_nxt.rq_tgl = !lk_r.rq_tgl;
              end
            end
          end else if (fall && lk_r.bcnt == ACK_BIT) begin
            lk_nxt.drv = 1'b0;
            lk_nxt.bcnt = 4'h0;
            if (lk_r.st == S_ADDR && lk_r.rw != DIR_WRITE) begin
              lk_nxt.st = S_RDATA;
              lk_nxt.sh = tx_byte;
              lk_nxt.drv = !tx_byte[7];
            end else if (lk_r.st == S_ADDR) begin
              lk_nxt.st = S_WORD;
            end else begin
              lk_nxt.st = S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (rise) begin
            lk_nxt.bcnt = lk_r.bcnt + 4'h1;
          end else if (fall && lk_r.bcnt < LAST_BIT) begin
            lk_nxt.sh = {lk_r.sh[6:0], 1'b0};
            lk_nxt.drv = !lk_r.sh[6];
          end else if (fall) begin
            // Fetch the next byte during the acknowledge slot
            lk_nxt.drv = 1'b0;
            lk_nxt.st = S_MACK;
            lk_nxt.ptr = rd_step(lk_r.ptr);
            lk_nxt.rq_addr = rd_step(lk_r.ptr);
            lk_nxt.rq_we = 1'b0;
            lk_nxt.rq_tgl = !lk_r.rq_tgl;
          end
        end
        S_MACK: begin
          if (rise) begin
            lk_nxt.mack = !sda_f;
          end else if (fall && lk_r.mack) begin
            lk_nxt.st = S_RDATA;
            lk_nxt.bcnt = 4'h0;
            lk_nxt.sh = tx_byte;
            lk_nxt.drv = !tx_byte[7];
          end else if (fall) begin
            lk_nxt.st = S_IDLE;
          end
        end
      endcase
    end
    if (lk_r.rst2) begin
      lk_nxt = '0;
      lk_nxt.ptr = PTR_RST;
      lk_nxt.scl_p = LINE_IDLE;
      lk_nxt.sda_p = LINE_IDLE;
      lk_nxt.rst1 = sys_rst;
      lk_nxt.rst2 = lk_r.rst1;
    end
  end

  always_ff @(posedge link_clk) begin
    lk_r <= lk_nxt;
  end

  // Register side, on ref_clk; request fields are held until the next byte
  always_comb begin
    rf_nxt = rf_r;
    rf_nxt.q1 = lk_r.rq_tgl;
    rf_nxt.q2 = rf_r.q1;
    rf_nxt.q3 = rf_r.q2;
    rf_nxt.rd = 1'b0;
    rf_nxt.wr = 1'b0;
    rf_nxt.pend = 1'b0;
    if (rf_r.q2 != rf_r.q3) begin
      rf_nxt.addr = lk_r.rq_addr;
      rf_nxt.wdata = lk_r.rq_wdata;
      rf_nxt.wr = lk_r.rq_we;
      rf_nxt.rd = !lk_r.rq_we;
    end
    if (rf_r.rd) begin
      rf_nxt.pend = 1'b1;
    end
    if (rf_r.pend) begin
      rf_nxt.rd_hold = reg_rdata;
      rf_nxt.ak_tgl = !rf_r.ak_tgl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rf_r <= '0;
    end else begin
      rf_r <= rf_nxt;
    end
  end

  assign reg_addr = rf_r.addr;
  assign reg_wdata = rf_r.wdata;
  assign reg_wr = rf_r.wr;
  assign reg_rd = rf_r.rd;
  // Only ever pulls SDA low; SCL is never driven
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = lk_r.drv;
endmodule

// *** hw/i2c_bus_master.sv ***
`timescale 1ns/100ps
module i2c_bus_master (
  input wire logic ref_clk,
  input wire logic sys_rst,
  i2c_link_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import i2c_link_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_BUF} m_st_t;

  typedef struct packed {
    m_st_t st;
    logic [4:0] qcnt;
    logic [1:0] ph;
    logic [3:0] bcnt;
    logic [8:0] sh;
    logic [8:0] rx;
    logic stop;
    logic held;
    logic scl;
    logic sda;
    logic rsp_v;
    logic [7:0] rsp_d;
    logic rsp_n;
  } m_t;

  m_t r_r;
  m_t r_nxt;
  logic sda_f;
  logic tick;

  i2c_line_filter #(.STABLE(4'(FILT_REF_CYC))) u_sda_flt (
    .clk(ref_clk),
    .rst(sys_rst),
    .din(bus.sda),
    .dout(sda_f)
  );

  assign tick = (r_r.qcnt == QTR_CYC - 5'd1);

  always_comb begin
    r_nxt = r_r;
    r_nxt.rsp_v = 1'b0;
    r_nxt.qcnt = tick ? 5'd0 : r_r.qcnt + 5'd1;
    if (tick && r_r.st != M_IDLE) begin
      r_nxt.ph = r_r.ph + 2'd1;
    end
    unique case (r_r.st)
      M_IDLE: begin
        if (cmd_valid) begin
          // Read bytes carry the ack this end returns; writes release it
          r_nxt.sh = cmd_read ? {8'hff, cmd_nack} : {cmd_wdata, 1'b1};
          r_nxt.stop = cmd_stop;
          r_nxt.ph = 2'd0;
          r_nxt.bcnt = 4'h0;
          r_nxt.st = (cmd_start || !r_r.held) ? M_START : M_BIT;
        end
      end
      M_START: begin
        if (tick) begin
          unique case (r_r.ph)
            2'd0: r_nxt.sda = 1'b1;
            2'd1: r_nxt.scl = 1'b1;
            2'd2: r_nxt.sda = 1'b0;
            2'd3: begin
              r_nxt.scl = 1'b0;
              r_nxt.held = 1'b1;
              r_nxt.st = M_BIT;
            end
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          unique case (r_r.ph)
            2'd0: r_nxt.sda = r_r.sh[8];
            2'd1: r_nxt.scl = 1'b1;
            2'd2: r_nxt.rx = {r_r.rx[7:0], sda_f};
            2'd3: begin
              r_nxt.scl = 1'b0;
              r_nxt.sh = {r_r.sh[7:0], 1'b1};
              r_nxt.bcnt = r_r.bcnt + 4'h1;
              if (r_r.bcnt == LAST_BIT) begin
                r_nxt.rsp_v = 1'b1;
                r_nxt.rsp_d = r_r.rx[8:1];
                r_nxt.rsp_n = r_r.rx[0];
                r_nxt.st = r_r.stop ? M_STOP : M_IDLE;
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          unique case (r_r.ph)
            2'd0: r_nxt.sda = 1'b0;
            2'd1: r_nxt.scl = 1'b1;
            2'd2: r_nxt.sda = 1'b1;
            2'd3: begin
              r_nxt.held = 1'b0;
              r_nxt.st = M_BUF;
            end
          endcase
        end
      end
      M_BUF: begin
        // Bus free time before the next START
        if (tick && r_r.ph == BUF_QTR - 2'd1) begin
          r_nxt.st = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_r <= '0;
      r_r.scl <= LINE_IDLE;
      r_r.sda <= LINE_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cmd_ready = (r_r.st == M_IDLE);
  assign rsp_valid = r_r.rsp_v;
  assign rsp_data = r_r.rsp_d;
  assign rsp_nack = r_r.rsp_n;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = !r_r.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = !r_r.sda;
endmodule

// *** dv/i2c_reg_slave_sva.sv ***
`timescale 1ns/100ps
module i2c_reg_slave_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic s_sda_oe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr
);
  import i2c_link_pkg::*;
  // Nine bit times plus seen-fall jitter
  localparam int OE_MAX = 370;
  // Bus timing minimums, rounded up to whole clock cycles
  localparam int T_LOW_NS = 500;
  localparam int T_HIGH_NS = 260;
  localparam int LOW_MIN_CYC =
    (T_LOW_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int HIGH_MIN_CYC =
    (T_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int BUF_MIN_CYC =
    (T_BUF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  logic [9:0] oe_run_r;
  logic scl_q;
  logic sda_q;
  logic busy_r;
  logic [5:0] lo_run_r;
  logic [5:0] hi_run_r;
  logic [5:0] free_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence start_cond;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $past(scl) && $rose(sda);
  endsequence
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !s_sda_oe) begin
      oe_run_r <= 10'h000;
    end else if (oe_run_r != 10'h3ff) begin
      oe_run_r <= oe_run_r + 10'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (sys_rst) begin
      busy_r <= 1'b0;
      lo_run_r <= 6'h00;
      hi_run_r <= 6'h00;
      free_r <= 6'h00;
    end else begin
      // Repeated START keeps the bus busy, only a STOP frees it
      if (scl && scl_q && sda_q && !sda) begin
        busy_r <= 1'b1;
      end else if (scl && scl_q && !sda_q && sda) begin
        busy_r <= 1'b0;
      end
      if (scl) begin
        lo_run_r <= 6'h00;
      end else if (lo_run_r != 6'h3f) begin
        lo_run_r <= lo_run_r + 6'h01;
      end
      if (!scl) begin
        hi_run_r <= 6'h00;
      end else if (hi_run_r != 6'h3f) begin
        hi_run_r <= hi_run_r + 6'h01;
      end
      if (!(scl && sda)) begin
        free_r <= 6'h00;
      end else if (free_r != 6'h3f) begin
        free_r <= free_r + 6'h01;
      end
    end
  end
  a_wr_map_only: assert property (reg_wr |-> WRITE_MAP_DEF[reg_addr])
    else $error("write strobe on protected address");
  a_wr_spacing: assert property (reg_wr |=> !reg_wr [*8])
    else $error("write strobes too close");
  a_rd_spacing: assert property (reg_rd |=> !reg_rd [*8])
    else $error("read strobes too close");
  a_addr_holds: assert property (reg_rd |=> $stable(reg_addr))
    else $error("address moved during read");
  a_no_stretch: assert property (scl == !m_scl_oe)
    else $error("clock held low by device");
  a_sda_stable_high: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device moved data while clock high");
  a_ack_pulls_low: assert property (
    $rose(scl) && s_sda_oe |-> (s_sda_oe && !sda) [*8])
    else $error("device drive not held low through clock high");
  a_quiet_after_start: assert property (
    start_cond |-> !s_sda_oe [*8])
    else $error("device drives after start");
  a_quiet_after_stop: assert property (
    stop_cond |=> !s_sda_oe [*8])
    else $error("device drives after stop");
  a_oe_run_bounded: assert property (oe_run_r <= OE_MAX)
    else $error("device drive longer than nine bits");
  a_scl_low_min: assert property (
    $rose(scl) |-> lo_run_r >= LOW_MIN_CYC)
    else $error("clock low phase too short");
  a_scl_high_min: assert property (
    $fell(scl) |-> hi_run_r >= HIGH_MIN_CYC)
    else $error("clock high phase too short");
  a_bus_free: assert property (
    start_cond |-> busy_r || free_r >= BUF_MIN_CYC)
    else $error("start too soon after stop");
endmodule

// *** dv/i2c_slave_register_pointer_tb.sv ***
`timescale 1ns/100ps
module i2c_slave_register_pointer_tb;
  import i2c_link_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [11:0] cmd_r = 12'h000;
  logic cmd_ready, rsp_valid, rsp_nack, reg_wr, reg_rd;
  logic [7:0] rsp_data, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] regs [256];
  logic [8:0] sh = 9'h000;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  i2c_link_if link ();
  i2c_reg_slave u_i2c_reg_slave (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .bus(link), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  i2c_bus_master u_i2c_bus_master (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_start(cmd_r[11]), .cmd_stop(cmd_r[10]), .cmd_read(cmd_r[9]),
    .cmd_nack(cmd_r[8]), .cmd_wdata(cmd_r[7:0]), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  i2c_reg_slave_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .scl(link.scl), .sda(link.sda), .m_scl_oe(link.m_scl_oe),
    .s_sda_oe(link.s_sda_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr));
  initial forever #12.5 ref_clk = ~ref_clk;
  // Odd offset keeps the link clock out of phase
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  initial for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5c;
  always @(posedge ref_clk) if (reg_wr) regs[reg_addr] <= reg_wdata;
  assign reg_rdata = regs[reg_addr];
  always @(posedge link.scl) sh <= {sh[7:0], link.sda};
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input string w, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", w, e, g);
    end
  endtask
  function automatic logic [7:0] ex(input logic [7:0] a);
    return VALID_MAP_DEF[a] ? regs[a] : 8'h00;
  endfunction
  task automatic xfer(input logic s, p, r, k, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_r = {s, p, r, k, d};
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk1("rsp", 1'b1, rsp_valid);
  endtask
  task automatic wb(input logic s, p, input logic [7:0] d, input logic nk);
    xfer(s, p, 1'b0, 1'b0, d);
    chk1("ack", nk, rsp_nack);
  endtask
  task automatic rb(input logic p, k, input logic [7:0] e);
    xfer(1'b0, p, 1'b1, k, 8'h00);
    chk8("rdata", e, rsp_data);
    chk8("wire", e, sh[8:1]);
  endtask
  task automatic sc_first_read();
    wb(1'b1, 1'b0, 8'h6d, 1'b0);
    rb(1'b1, 1'b1, ex(8'h00));
  endtask
  task automatic sc_bad_dev();
    wb(1'b1, 1'b1, 8'h6e, 1'b1);
  endtask
  task automatic sc_write();
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b0, 8'h07, 1'b0);
    wb(1'b0, 1'b0, 8'ha5, 1'b0);
    wb(1'b0, 1'b0, 8'h5a, 1'b0);
    wb(1'b0, 1'b1, 8'h33, 1'b1);
    chk8("reg 07", 8'ha5, regs[7]);
    chk8("reg 08", 8'h5a, regs[8]);
    chk8("reg 09", 8'h55, regs[9]);
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b0, 8'h07, 1'b0);
    wb(1'b1, 1'b0, 8'h6d, 1'b0);
    rb(1'b0, 1'b0, 8'ha5);
    rb(1'b0, 1'b0, 8'h5a);
    rb(1'b0, 1'b0, 8'h00);
    rb(1'b0, 1'b0, 8'h00);
    rb(1'b1, 1'b1, 8'h57);
  endtask
  task automatic sc_wrap();
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b0, 8'hff, 1'b0);
    wb(1'b0, 1'b0, 8'hc3, 1'b0);
    wb(1'b0, 1'b0, 8'h11, 1'b1);
    wb(1'b0, 1'b1, 8'h22, 1'b0);
    chk8("reg 00", 8'h5c, regs[0]);
    chk8("reg 01", 8'h22, regs[1]);
    chk8("reg ff", 8'hc3, regs[255]);
  endtask
  task automatic sc_bad_ptr();
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b1, 8'h10, 1'b1);
    wb(1'b1, 1'b0, 8'h6d, 1'b0);
    rb(1'b0, 1'b0, 8'h00);
    rb(1'b1, 1'b1, 8'h00);
  endtask
  task automatic sc_hold(input logic [7:0] a, b, c, d);
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b0, a, 1'b0);
    wb(1'b1, 1'b0, 8'h6d, 1'b0);
    rb(1'b0, 1'b0, ex(b));
    rb(1'b0, 1'b0, ex(c));
    rb(1'b1, 1'b1, ex(d));
  endtask
  task automatic sc_read_wrap();
    wb(1'b1, 1'b0, 8'h6c, 1'b0);
    wb(1'b0, 1'b0, 8'hfe, 1'b1);
    wb(1'b1, 1'b0, 8'h6d, 1'b0);
    rb(1'b0, 1'b0, 8'h00);
    rb(1'b0, 1'b0, ex(8'hff));
    rb(1'b1, 1'b1, ex(8'h00));
  endtask
  // STOP and bus free time finish well inside this wait
  task automatic wait_idle();
    repeat (120) @(posedge ref_clk);
    #1;
  endtask
  // Pointer was left at 0x01 by the read wrap; reset must bring it to zero
  task automatic sc_reset();
    wait_idle();
    sys_rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    sc_first_read();
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    sc_first_read();
    sc_bad_dev();
    sc_write();
    sc_wrap();
    sc_bad_ptr();
    sc_hold(8'h0c, 8'h0c, 8'h0c, 8'h0c);
    sc_hold(8'h0d, 8'h0d, 8'h0e, 8'h0e);
    sc_read_wrap();
    sc_reset();
    wait_idle();
    chk1("scl idle", 1'b1, link.scl);
    chk1("sda idle", 1'b1, link.sda);
    stop_test();
  end
endmodule
